// ### verilog/sbw_defs.vh
`ifndef SBW_DEFS_VH
`define SBW_DEFS_VH

// frame control characters
`define SBW_ENQ 8'h05
`define SBW_EOT 8'h04
`define SBW_ACK 8'h06
`define SBW_NAK 8'h15
`define SBW_ETX 8'h03

// command letters, upper case; the case bit selects the checksum
`define SBW_CMD_WRITE 8'h57
`define SBW_CMD_MONREG 8'h58
`define SBW_CASE_BIT 8'h20

// type and format code characters
`define SBW_CHR_S 8'h53
`define SBW_CHR_B 8'h42
`define SBW_CHR_R 8'h52
`define SBW_CHR_PCT 8'h25

// ascii ranges used for hex coding and name checking
`define SBW_CHR_0 8'h30
`define SBW_CHR_1 8'h31
`define SBW_CHR_9 8'h39
`define SBW_CHR_UA 8'h41
`define SBW_CHR_UF 8'h46
`define SBW_CHR_UZ 8'h5A
`define SBW_CHR_LA 8'h61
`define SBW_CHR_LZ 8'h7A
`define SBW_HEX_TEN 4'hA

// field limits
`define SBW_NAME_MIN 5'h01
`define SBW_NAME_MAX 5'h10
`define SBW_WORDS_MIN 7'h01
`define SBW_WORDS_MAX 7'h3C

// characters per field
`define SBW_HEX2_LEN 8'h02
`define SBW_RSS_LEN 8'h05
`define SBW_RSB_LEN 8'h03
`define SBW_ONE_LEN 8'h01
`define SBW_ERR_LEN 3'h4

// default reply timeout in cycles, 50 ms at 200 MHz
`define SBW_REPLY_TIMEOUT 24'h98_9680

`endif

// ### verilog/sbw_tx_stage.v
`include "sbw_defs.vh"
`default_nettype none

// one-byte output stage toward the serial transmitter
module sbw_tx_stage (
   input wire clk,
   input wire rst_n,
   input wire in_valid,
   input wire [7:0] in_byte,
   output wire in_ready,
   output reg tx_valid,
   output reg [7:0] tx_byte,
   input wire tx_ready
);

   // accept a new byte when empty or when the held one leaves now,
   // so a steady stream costs no bubble cycles
   assign in_ready = !tx_valid || tx_ready;

   // holding register; the transmitter stalls us through tx_ready
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_valid <= 1'b0;
         tx_byte <= 8'h00;
      end
      else if (in_ready)
      begin
         tx_valid <= in_valid;
         tx_byte <= in_valid ? in_byte : tx_byte;
      end
   end

endmodule

`default_nettype wire

// ### verilog/sbw_rx_parse.v
`include "sbw_defs.vh"
`default_nettype none

// parser for acknowledge and negative replies from the device
module sbw_rx_parse (
   input wire clk,
   input wire rst_n,
   input wire arm,
   input wire lower,
   input wire [7:0] exp_station,
   input wire [7:0] exp_cmd,
   input wire [15:0] exp_echo,
   input wire rx_valid,
   input wire [7:0] rx_byte,
   output reg done,
   output reg ack,
   output reg nak,
   output reg bad,
   output reg [15:0] err_code
);

   localparam P_IDLE = 4'd0;
   localparam P_HDR = 4'd1;
   localparam P_ST0 = 4'd2;
   localparam P_ST1 = 4'd3;
   localparam P_CMD = 4'd4;
   localparam P_EC0 = 4'd5;
   localparam P_EC1 = 4'd6;
   localparam P_ERR = 4'd7;
   localparam P_TAIL = 4'd8;
   localparam P_BCC0 = 4'd9;
   localparam P_BCC1 = 4'd10;

   reg [3:0] state_reg; // parse position
   reg [2:0] idx_reg; // error code digit index
   reg [7:0] sum_reg; // running byte sum
   reg is_nak_reg; // reply header was negative

   // nibble to upper-case ascii hex
   function [7:0] hex_char;
      input [3:0] n;
      begin
         if (n < `SBW_HEX_TEN)
            hex_char = `SBW_CHR_0 + {4'h0, n};
         else
            hex_char = `SBW_CHR_UA + {4'h0, n - `SBW_HEX_TEN};
      end
   endfunction

   // upper-case ascii hex digit back to a nibble; anything else reads as zero
   function [3:0] char_nib;
      input [7:0] c;
      begin
         if (c >= `SBW_CHR_0 && c <= `SBW_CHR_9)
            char_nib = c[3:0];
         else if (c >= `SBW_CHR_UA && c <= `SBW_CHR_UF)
            char_nib = c[3:0] + 4'h9;
         else
            char_nib = 4'h0;
      end
   endfunction

   reg [7:0] exp_char; // character that must arrive in this position
   reg match_ok; // received byte fits the position

   // expected character for each fixed position
   always @*
   begin
      exp_char = 8'h00;
      match_ok = 1'b1;
      case (state_reg)
         P_ST0: exp_char = hex_char(exp_station[7:4]);
         P_ST1: exp_char = hex_char(exp_station[3:0]);
         P_CMD: exp_char = exp_cmd;
         P_EC0: exp_char = exp_echo[15:8];
         P_EC1: exp_char = exp_echo[7:0];
         P_TAIL: exp_char = `SBW_ETX;
         P_BCC0: exp_char = hex_char(sum_reg[7:4]);
         P_BCC1: exp_char = hex_char(sum_reg[3:0]);
         default: exp_char = rx_byte;
      endcase
      if (state_reg == P_HDR)
         match_ok = (rx_byte == `SBW_ACK) || (rx_byte == `SBW_NAK);
      else
         match_ok = (rx_byte == exp_char);
   end

   // byte-by-byte walk; any mismatch ends the reply as bad at once
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= P_IDLE;
         idx_reg <= 3'h0;
         sum_reg <= 8'h00;
         is_nak_reg <= 1'b0;
         done <= 1'b0;
         ack <= 1'b0;
         nak <= 1'b0;
         bad <= 1'b0;
         err_code <= 16'h0000;
      end
      else
      begin
         done <= 1'b0;
         ack <= 1'b0;
         nak <= 1'b0;
         bad <= 1'b0;
         if (arm)
         begin
            state_reg <= P_HDR;
            idx_reg <= 3'h0;
            sum_reg <= 8'h00;
         end
         else if (rx_valid && state_reg != P_IDLE)
         begin
            // check sum covers header through end-of-text only
            if (state_reg != P_BCC0 && state_reg != P_BCC1)
               sum_reg <= sum_reg + rx_byte;
            if (!match_ok)
            begin
               done <= 1'b1;
               bad <= 1'b1;
               state_reg <= P_IDLE;
            end
            else
            begin
               case (state_reg)
                  P_HDR:
                  begin
                     is_nak_reg <= (rx_byte == `SBW_NAK);
                     state_reg <= P_ST0;
                  end
                  P_ST0: state_reg <= P_ST1;
                  P_ST1: state_reg <= P_CMD;
                  P_CMD: state_reg <= P_EC0;
                  P_EC0: state_reg <= P_EC1;
                  P_EC1: state_reg <= is_nak_reg ? P_ERR : P_TAIL;
                  P_ERR:
                  begin
                     err_code <= {err_code[11:0], char_nib(rx_byte)};
                     idx_reg <= idx_reg + 3'h1;
                     if (idx_reg == `SBW_ERR_LEN - 3'h1)
                        state_reg <= P_TAIL;
                  end
                  P_TAIL:
                  begin
                     if (lower)
                        state_reg <= P_BCC0;
                     else
                     begin
                        done <= 1'b1;
                        ack <= !is_nak_reg;
                        nak <= is_nak_reg;
                        state_reg <= P_IDLE;
                     end
                  end
                  P_BCC0: state_reg <= P_BCC1;
                  P_BCC1:
                  begin
                     done <= 1'b1;
                     ack <= !is_nak_reg;
                     nak <= is_nak_reg;
                     state_reg <= P_IDLE;
                  end
                  default: state_reg <= P_IDLE;
               endcase
            end
         end
      end
   end

endmodule

`default_nettype wire

// ### verilog/sbw_host.v
`include "sbw_defs.vh"
`default_nettype none

// host-side frame builder for continuous write and monitor registration
module sbw_host #(
   parameter [23:0] REPLY_TIMEOUT = `SBW_REPLY_TIMEOUT,
   parameter MAX_WORDS = 60,
   parameter NAME_DEPTH = 16
) (
   input wire clk,
   input wire reset_n,
   input wire cmd_start,
   input wire cmd_monitor,
   input wire cmd_lower,
   input wire cmd_block_fmt,
   input wire [7:0] station,
   input wire [3:0] reg_no,
   input wire [4:0] name_len,
   input wire name_we,
   input wire [3:0] name_idx,
   input wire [7:0] name_char,
   input wire data_we,
   input wire [5:0] data_idx,
   input wire [15:0] data_word,
   input wire [6:0] data_count,
   output wire tx_valid,
   output wire [7:0] tx_byte,
   input wire tx_ready,
   input wire rx_valid,
   input wire [7:0] rx_byte,
   output reg busy,
   output reg cmd_error,
   output reg timed_out,
   output wire done,
   output wire reply_ack,
   output wire reply_nak,
   output wire reply_bad,
   output wire [15:0] err_code
);

   localparam S_IDLE = 4'd0;
   localparam S_HDR = 4'd1;
   localparam S_STN = 4'd2;
   localparam S_CMD = 4'd3;
   localparam S_TYP = 4'd4;
   localparam S_FMT = 4'd5;
   localparam S_LEN = 4'd6;
   localparam S_NAME = 4'd7;
   localparam S_CNT = 4'd8;
   localparam S_DATA = 4'd9;
   localparam S_TAIL = 4'd10;
   localparam S_BCC = 4'd11;
   localparam S_WAIT = 4'd12;

   reg rst_meta_reg; // reset release, first stage
   reg rst_n; // reset release, usable copy

   // release reset through two flops; assertion stays asynchronous
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   reg [7:0] name_mem [0:NAME_DEPTH-1]; // device name characters
   reg [15:0] data_mem [0:MAX_WORDS-1]; // words to write

   // user loads name and data before starting; no reset needed
   always @(posedge clk)
   begin
      if (name_we)
         name_mem[name_idx] <= name_char;
      if (data_we)
         data_mem[data_idx] <= data_word;
   end

   reg [3:0] state_reg; // frame position
   reg [7:0] idx_reg; // character index within field
   reg [7:0] sum_reg; // running checksum of sent bytes
   reg [23:0] wait_reg; // reply timeout counter
   reg mon_reg; // latched: monitor registration
   reg lower_reg; // latched: lowercase letter
   reg block_reg; // latched: block read format
   reg [7:0] stn_reg; // latched station
   reg [3:0] regno_reg; // latched registration number
   reg [4:0] len_reg; // latched name length
   reg [6:0] cnt_reg; // latched unit count
   reg arm_reg; // start pulse to the reply parser

   // nibble to upper-case ascii hex
   function [7:0] hex_char;
      input [3:0] n;
      begin
         if (n < `SBW_HEX_TEN)
            hex_char = `SBW_CHR_0 + {4'h0, n};
         else
            hex_char = `SBW_CHR_UA + {4'h0, n - `SBW_HEX_TEN};
      end
   endfunction

   // legal device name character
   function name_char_ok;
      input [7:0] c;
      begin
         name_char_ok = (c >= `SBW_CHR_0 && c <= `SBW_CHR_9) ||
                        (c >= `SBW_CHR_UA && c <= `SBW_CHR_UZ) ||
                        (c >= `SBW_CHR_LA && c <= `SBW_CHR_LZ) ||
                        (c == `SBW_CHR_PCT);
      end
   endfunction

   reg name_ok; // every used name character legal
   reg len_ok; // name length in range
   reg cnt_ok; // unit count in range
   integer i;

   // validate the request before any byte goes out, so the device
   // never sees a frame the host already knows to be illegal
   always @*
   begin
      name_ok = 1'b1;
      for (i = 0; i < NAME_DEPTH; i = i + 1)
      begin
         if (i < name_len && !name_char_ok(name_mem[i]))
            name_ok = 1'b0;
      end
      len_ok = (name_len >= `SBW_NAME_MIN) && (name_len <= `SBW_NAME_MAX);
      cnt_ok = (data_count >= `SBW_WORDS_MIN) && (data_count <= `SBW_WORDS_MAX);
      if (cmd_monitor && !cmd_block_fmt)
         cnt_ok = 1'b1;
   end

   reg [7:0] cur_limit; // characters in current field
   reg [7:0] cur_char; // character for current position
   reg [15:0] cur_word; // data word being sent
   reg [3:0] next_state; // field after the current one

   // field lengths and characters for each frame position
   always @*
   begin
      cur_limit = `SBW_ONE_LEN;
      cur_char = `SBW_ENQ;
      cur_word = data_mem[idx_reg[7:2]];
      next_state = S_IDLE;
      case (state_reg)
         S_HDR:
         begin
            cur_char = `SBW_ENQ;
            next_state = S_STN;
         end
         S_STN:
         begin
            cur_limit = `SBW_HEX2_LEN;
            cur_char = idx_reg[0] ? hex_char(stn_reg[3:0]) : hex_char(stn_reg[7:4]);
            next_state = S_CMD;
         end
         S_CMD:
         begin
            cur_char = (mon_reg ? `SBW_CMD_MONREG : `SBW_CMD_WRITE) |
                       (lower_reg ? `SBW_CASE_BIT : 8'h00);
            next_state = S_TYP;
         end
         S_TYP:
         begin
            cur_limit = `SBW_HEX2_LEN;
            if (mon_reg)
               cur_char = idx_reg[0] ? hex_char(regno_reg) : `SBW_CHR_0;
            else
               cur_char = idx_reg[0] ? `SBW_CHR_B : `SBW_CHR_S;
            next_state = mon_reg ? S_FMT : S_LEN;
         end
         S_FMT:
         begin
            cur_limit = block_reg ? `SBW_RSB_LEN : `SBW_RSS_LEN;
            case (idx_reg[2:0])
               3'd0: cur_char = `SBW_CHR_R;
               3'd1: cur_char = `SBW_CHR_S;
               3'd2: cur_char = block_reg ? `SBW_CHR_B : `SBW_CHR_S;
               3'd3: cur_char = `SBW_CHR_0;
               default: cur_char = `SBW_CHR_1;
            endcase
            next_state = S_LEN;
         end
         S_LEN:
         begin
            cur_limit = `SBW_HEX2_LEN;
            cur_char = idx_reg[0] ? hex_char(len_reg[3:0]) : hex_char({3'b000, len_reg[4]});
            next_state = S_NAME;
         end
         S_NAME:
         begin
            cur_limit = {3'b000, len_reg};
            cur_char = name_mem[idx_reg[3:0]];
            next_state = (mon_reg && !block_reg) ? S_TAIL : S_CNT;
         end
         S_CNT:
         begin
            cur_limit = `SBW_HEX2_LEN;
            cur_char = idx_reg[0] ? hex_char(cnt_reg[3:0]) : hex_char({1'b0, cnt_reg[6:4]});
            next_state = mon_reg ? S_TAIL : S_DATA;
         end
         S_DATA:
         begin
            cur_limit = {cnt_reg[5:0], 2'b00};
            case (idx_reg[1:0])
               2'd0: cur_char = hex_char(cur_word[15:12]);
               2'd1: cur_char = hex_char(cur_word[11:8]);
               2'd2: cur_char = hex_char(cur_word[7:4]);
               default: cur_char = hex_char(cur_word[3:0]);
            endcase
            next_state = S_TAIL;
         end
         S_TAIL:
         begin
            cur_char = `SBW_EOT;
            next_state = lower_reg ? S_BCC : S_WAIT;
         end
         S_BCC:
         begin
            // low byte of sum, in hex
            cur_limit = `SBW_HEX2_LEN;
            cur_char = idx_reg[0] ? hex_char(sum_reg[3:0]) : hex_char(sum_reg[7:4]);
            next_state = S_WAIT;
         end
         default:
         begin
            cur_limit = `SBW_ONE_LEN;
            cur_char = `SBW_ENQ;
            next_state = S_IDLE;
         end
      endcase
   end

   wire emit = (state_reg >= S_HDR) && (state_reg <= S_BCC); // byte offered
   wire emit_ready; // output stage takes the byte
   wire fire = emit && emit_ready; // byte taken this cycle
   wire field_end = (idx_reg == cur_limit - 8'h01); // last character of field

   // sequencer: latch the request, walk the fields, then wait for the reply
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= S_IDLE;
         idx_reg <= 8'h00;
         sum_reg <= 8'h00;
         wait_reg <= 24'h00_0000;
         mon_reg <= 1'b0;
         lower_reg <= 1'b0;
         block_reg <= 1'b0;
         stn_reg <= 8'h00;
         regno_reg <= 4'h0;
         len_reg <= 5'h00;
         cnt_reg <= 7'h00;
         arm_reg <= 1'b0;
         busy <= 1'b0;
         cmd_error <= 1'b0;
         timed_out <= 1'b0;
      end
      else
      begin
         arm_reg <= 1'b0;
         cmd_error <= 1'b0;
         timed_out <= 1'b0;
         case (state_reg)
            S_IDLE:
            begin
               if (cmd_start)
               begin
                  // illegal requests are refused without a frame
                  if (!(name_ok && len_ok && cnt_ok))
                     cmd_error <= 1'b1;
                  else
                  begin
                     mon_reg <= cmd_monitor;
                     lower_reg <= cmd_lower;
                     block_reg <= cmd_block_fmt;
                     stn_reg <= station;
                     regno_reg <= reg_no;
                     len_reg <= name_len;
                     cnt_reg <= data_count;
                     sum_reg <= 8'h00;
                     idx_reg <= 8'h00;
                     arm_reg <= 1'b1;
                     busy <= 1'b1;
                     state_reg <= S_HDR;
                  end
               end
            end
            S_WAIT:
            begin
               // a silent device (wrong station) must not hang the host
               wait_reg <= wait_reg + 24'h00_0001;
               if (done)
               begin
                  busy <= 1'b0;
                  state_reg <= S_IDLE;
               end
               else if (wait_reg >= REPLY_TIMEOUT - 24'h00_0001)
               begin
                  timed_out <= 1'b1;
                  busy <= 1'b0;
                  state_reg <= S_IDLE;
               end
            end
            default:
            begin
               if (fire)
               begin
                  if (state_reg != S_BCC)
                     sum_reg <= sum_reg + cur_char;
                  if (field_end)
                  begin
                     idx_reg <= 8'h00;
                     wait_reg <= 24'h00_0000;
                     state_reg <= next_state;
                  end
                  else
                     idx_reg <= idx_reg + 8'h01;
               end
            end
         endcase
      end
   end

   // output register toward the serial transmitter
   sbw_tx_stage u_tx (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(emit),
      .in_byte(cur_char),
      .in_ready(emit_ready),
      .tx_valid(tx_valid),
      .tx_byte(tx_byte),
      .tx_ready(tx_ready)
   );

   // reply checking; echo is type code or registration number
   sbw_rx_parse u_rx (
      .clk(clk),
      .rst_n(rst_n),
      .arm(arm_reg),
      .lower(lower_reg),
      .exp_station(stn_reg),
      .exp_cmd((mon_reg ? `SBW_CMD_MONREG : `SBW_CMD_WRITE) |
               (lower_reg ? `SBW_CASE_BIT : 8'h00)),
      .exp_echo(mon_reg ? {`SBW_CHR_0, hex_char(regno_reg)} : {`SBW_CHR_S, `SBW_CHR_B}),
      .rx_valid(rx_valid),
      .rx_byte(rx_byte),
      .done(done),
      .ack(reply_ack),
      .nak(reply_nak),
      .bad(reply_bad),
      .err_code(err_code)
   );

endmodule

`default_nettype wire

// ### verif/sbw_host_asserts.sv
`default_nettype none
module sbw_host_asserts (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic busy,
   input wire logic cmd_error,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_ready,
   input wire logic done,
   input wire logic reply_ack,
   input wire logic reply_nak,
   input wire logic reply_bad,
   input wire logic timed_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_byte_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("byte dropped");
   a_frame_opens: assert property ($rose(busy) |=> tx_valid && tx_byte == 8'h05)
      else $error("no header");
   a_refuse_quiet: assert property (cmd_error |-> !busy && !tx_valid)
      else $error("sent refused");
   a_idle_quiet: assert property (!busy |-> !tx_valid)
      else $error("idle send");
   a_one_verdict: assert property (done |-> $onehot({reply_ack, reply_nak, reply_bad}))
      else $error("verdict count");
   a_verdict_done: assert property (reply_ack || reply_nak || reply_bad |-> done)
      else $error("verdict alone");
   a_end_pulse: assert property (done || timed_out |-> busy == done ##1 !done && !timed_out)
      else $error("end pulse");
   a_timeout_alone: assert property (timed_out |-> !done && !cmd_error)
      else $error("timeout mix");
endmodule
bind sbw_host sbw_host_asserts u_chk (.clk, .reset_n, .busy, .cmd_error, .tx_valid, .tx_byte,
   .tx_ready, .done, .reply_ack, .reply_nak, .reply_bad, .timed_out);
`default_nettype wire

// ### verif/sbw_dev_model.sv
`default_nettype none
// device side: takes a request frame, answers ack, nak, nothing or a bad echo
module sbw_dev_model (
   input wire logic clk,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   input wire logic [1:0] mode,
   input wire logic slow,
   input wire logic [15:0] err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] fb [0:299];
   int n = 0, flen = 0, last_len = 0;
   function automatic logic [7:0] hx(input logic [3:0] v);
      return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
   endfunction
   task automatic reply();
      logic [7:0] rp [$];
      logic [7:0] s;
      logic lo;
      int k;
      lo = fb[3][5];
      s = 8'h00;
      for (k = 0; k < flen - (lo ? 2 : 0); k++)
         s += fb[k];
      last_len = flen;
      flen = 0;
      n = 0;
      // a bad request sum is never answered
      if (lo && (fb[last_len-2] != hx(s[7:4]) || fb[last_len-1] != hx(s[3:0])))
         return;
      // silence, as for a foreign station
      if (mode == 2'h2)
         return;
      // echo of station, letter and type or slot
      rp = {mode == 2'h1 ? 8'h15 : 8'h06, fb[1], fb[2], fb[3], fb[4], fb[5]};
      if (mode == 2'h3)
         rp[1] = ~rp[1];
      if (mode == 2'h1)
         rp = {rp, hx(err[15:12]), hx(err[11:8]), hx(err[7:4]), hx(err[3:0])};
      rp.push_back(8'h03);
      s = 8'h00;
      foreach (rp[j])
         s += rp[j];
      // sum of the reply for lower case letters
      if (lo)
         rp = {rp, hx(s[7:4]), hx(s[3:0])};
      foreach (rp[j])
      begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_byte <= rp[j];
         @(posedge clk);
         rx_valid <= 1'b0;
         rx_byte <= ~rp[j];
         if (slow)
            repeat (3) @(posedge clk);
      end
   endtask
   // capture bytes; the ready line toggles when slow to stall the sender
   initial
   begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      forever
      begin
         @(posedge clk);
         if (tx_valid && tx_ready)
         begin
            fb[n] = tx_byte;
            n++;
            if (tx_byte == 8'h04)
               flen = n + (fb[3][5] ? 2 : 0);
         end
         tx_ready <= slow ? !tx_ready : 1'b1;
         if (flen != 0 && n == flen)
            reply();
      end
   end
endmodule
`default_nettype wire

// ### verif/sbw_host_test.sv
`default_nettype none
module sbw_host_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset_n = 0, cmd_start = 0, cmd_monitor = 0, cmd_lower = 0, slow = 0;
   logic cmd_block_fmt = 0, name_we = 0, data_we = 0, tx_ready, rx_valid, tx_valid, busy;
   logic cmd_error, timed_out, done, reply_ack, reply_nak, reply_bad;
   logic [7:0] station = 8'h01, name_char = 8'h00, tx_byte, rx_byte;
   logic [3:0] reg_no = 4'h0, name_idx = 4'h0;
   logic [4:0] name_len = 5'h01;
   logic [5:0] data_idx = 6'h00;
   logic [6:0] data_count = 7'h01;
   logic [15:0] data_word = 16'h0000, err = 16'h0000, err_code;
   logic [1:0] mode = 2'h0;
   logic [7:0] nm [0:15];
   logic [7:0] q [$];
   int num_errors = 0, n_checks = 0;
   always #2.5 clk = ~clk;
   // short reply timeout so the silent case ends quickly
   sbw_host #(.REPLY_TIMEOUT(24'h00_00C8)) u_dut (.clk, .reset_n, .cmd_start, .cmd_monitor,
      .cmd_lower, .cmd_block_fmt, .station, .reg_no, .name_len, .name_we, .name_idx, .name_char,
      .data_we, .data_idx, .data_word, .data_count, .tx_valid, .tx_byte, .tx_ready, .rx_valid,
      .rx_byte, .busy, .cmd_error, .timed_out, .done, .reply_ack, .reply_nak, .reply_bad,
      .err_code);
   sbw_dev_model u_dev (.clk, .tx_valid, .tx_byte, .tx_ready, .rx_valid, .rx_byte, .mode,
      .slow, .err);
   function automatic logic [7:0] hx(input logic [3:0] v);
      return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
   endfunction
   function automatic logic [15:0] wd(input int i);
      return {8'hF0 ^ i[7:0], i[7:0] + 8'hA5};
   endfunction
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // name and data memories are loaded in one pass, one entry a cycle
   task automatic load(input string s, input int words);
      int i;
      for (i = 0; i < s.len() + words; i++)
      begin
         @(posedge clk);
         name_we <= i < s.len();
         data_we <= i >= s.len();
         name_idx <= i[3:0];
         name_char <= s[i];
         data_idx <= 6'(i - s.len());
         data_word <= wd(i - s.len());
         if (i < s.len())
            nm[i] = s[i];
      end
      @(posedge clk);
      name_we <= 1'b0;
      data_we <= 1'b0;
      name_len <= 5'(s.len());
      data_count <= 7'(words);
   endtask
   task automatic frame(input logic mon, lo, blk, input int words);
      int i;
      logic [7:0] s;
      logic [15:0] w;
      q = {8'h05, hx(station[7:4]), hx(station[3:0]), (mon ? 8'h58 : 8'h57) | (lo ? 8'h20 : 8'h00)};
      if (mon)
         q = {q, 8'h30, hx(reg_no), 8'h52, 8'h53, blk ? 8'h42 : 8'h53};
      else
         q = {q, 8'h53, 8'h42};
      if (mon && !blk)
         q = {q, 8'h30, 8'h31};
      q = {q, hx({3'h0, name_len[4]}), hx(name_len[3:0])};
      for (i = 0; i < name_len; i++)
         q.push_back(nm[i]);
      if (!mon || blk)
         q = {q, hx({1'b0, data_count[6:4]}), hx(data_count[3:0])};
      for (i = 0; i < words && !mon; i++)
      begin
         w = wd(i);
         q = {q, hx(w[15:12]), hx(w[11:8]), hx(w[7:4]), hx(w[3:0])};
      end
      q.push_back(8'h04);
      s = 8'h00;
      foreach (q[j])
         s += q[j];
      if (lo)
         q = {q, hx(s[7:4]), hx(s[3:0])};
      chk("frame length", 16'(q.size()), 16'(u_dev.last_len));
      foreach (q[j])
         chk("frame byte", {8'h00, q[j]}, {8'h00, u_dev.fb[j]});
   endtask
   // want: 0 ack, 1 nak, 2 bad reply, 3 timeout, 4 refused
   task automatic go(input logic mon, lo, blk, input int words, want);
      int t;
      logic [4:0] seen;
      seen = 5'h00;
      @(posedge clk);
      cmd_monitor <= mon;
      cmd_lower <= lo;
      cmd_block_fmt <= blk;
      cmd_start <= 1'b1;
      @(posedge clk);
      cmd_start <= 1'b0;
      for (t = 0; t < 3000 && seen == 5'h00; t++)
      begin
         @(negedge clk);
         seen = {cmd_error, timed_out, reply_bad, reply_nak, reply_ack};
      end
      chk("outcome", 16'h0001 << want, {11'h000, seen});
      if (t == 3000)
         finish_test();
      if (want == 4)
         chk("bytes sent", 16'h0000, 16'(u_dev.n));
      else
         frame(mon, lo, blk, words);
      repeat (3) @(posedge clk);
   endtask
   task automatic t_write_nak();
      mode <= 2'h1;
      err <= 16'h1132;
      load("M7", 2);
      go(0, 1, 0, 2, 1);
      chk("error code", 16'h1132, err_code);
   endtask
   task automatic t_refuse();
      int k;
      for (k = 0; k < 5; k++)
      begin
         load(k == 4 ? "A-1" : "%MW0", 2);
         @(posedge clk);
         if (k < 2)
            name_len <= k ? 5'h11 : 5'h00;
         if (k == 2 || k == 3)
            data_count <= k == 2 ? 7'h00 : 7'h3D;
         go(0, 0, 0, 2, 4);
      end
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      load("%DW000", 1);
      go(0, 0, 0, 1, 0);
      station <= 8'h1A;
      slow <= 1'b1;
      load("%mw9", 60);
      go(0, 1, 0, 60, 0);
      t_write_nak();
      mode <= 2'h0;
      slow <= 1'b0;
      reg_no <= 4'hF;
      load("%MW0a", 0);
      go(1, 0, 0, 0, 0);
      reg_no <= 4'h0;
      load("D1", 4);
      go(1, 1, 1, 4, 0);
      go(1, 1, 1, 4, 0);
      t_refuse();
      mode <= 2'h2;
      load("%MX1", 1);
      go(0, 0, 0, 1, 3);
      mode <= 2'h3;
      go(0, 0, 0, 1, 2);
      finish_test();
   end
endmodule
`default_nettype wire
